//--- hw/spag_core.sv
// Stack pointer, frame pointer and data page address generation.
// Function
// [RL1] One register is the stack pointer, auto-updated yet writable by software.
// [RL2] Stack pointer bit zero is always zero; writes to it are ignored.
// [RL3] Every reset loads the stack pointer with 0x1000.
// [RL4] Pointer marks next free word; stack grows upward.
// [RL5] Pop decrements then reads; push writes then increments.
// [RL6] Saved PC: low sixteen bits first, then bits 22 to 16.
// [RL7] Call saves zero-fill the upper bits of the second word.
// [RL8] Exception saves put status low byte above PC upper bits.
// [RL9] Stack accesses are never paged; frame too when frame active.
// [RL10] Core control bit 2 forces unpaged frame and stack accesses.
// [RL11] Page registers map 32-Kbyte windows into upper data space.
// [RL12] Read page of 0x200 or more reads program space.
// [RL13] Write page covers data space only, never program space.
// [RL14] Paged reads use read page; paged writes use write page.
// [RL15] Each push or pop moves the stack pointer by two.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module spag_core
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire spag_pkg::spag_reg_req_s i_reg,
    output logic [15:0] o_rdata,
    // Stack requests from the pipeline
    input wire spag_pkg::spag_op_e i_stk_op,
    input wire spag_pkg::spag_src_e i_stk_src,
    input wire logic [15:0] i_stk_data,
    input wire logic [22:0] i_pc,
    input wire logic [7:0] i_status_low,
    // Data accesses from the pipeline
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic i_acc_frame,
    input wire logic i_acc_stack,
    input wire logic [15:0] i_acc_ea,
    // Stack memory side
    output logic o_stk_valid,
    output logic o_stk_write,
    output logic [15:0] o_stk_addr,
    output logic [15:0] o_stk_wdata,
    output logic o_stk_busy,
    // Translated data access
    output logic o_acc_valid,
    output spag_pkg::spag_xlat_s o_acc_xlat,
    // Status
    output logic [15:0] o_stack_ptr,
    output logic o_stack_frame_active
);
    import spag_pkg::*;

    typedef enum logic [2:0]
    {
        SPAG_ST_IDLE = 3'b001,
        SPAG_ST_HIGH = 3'b010,
        SPAG_ST_DONE = 3'b100
    } spag_state_e;

    logic [15:0] stack_pointer_reg;
    logic [15:0] frame_pointer_reg;
    logic [15:0] core_control;
    logic [9:0] read_page_reg;
    logic [8:0] write_page_reg;
    spag_state_e state;
    spag_state_e next_state;
    spag_src_e save_src;
    logic upper_half;
    logic [15:0] push_word;
    logic [15:0] next_sp;
    logic stack_ref;
    spag_xlat_s xlat;

    default clocking spag_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    function automatic logic [15:0] sp_align(input logic [15:0] v);
        sp_align = {v[15:1], 1'b0}; // [RL2]
    endfunction : sp_align

    function automatic logic [15:0] sp_step(input logic [15:0] v,
                                            input logic up);
        // Memory is byte addressed, so one word is two bytes.
        sp_step = up ? sp_align(v + SP_STEP) : sp_align(v - SP_STEP); // [RL15]
    endfunction : sp_step

    assign o_stack_frame_active = core_control[SFA_BIT];

    // Two-word saves hold the pipeline for one extra cycle.
    always_comb
    begin
        next_state = state;
        case (state)
            SPAG_ST_IDLE:
                if (i_stk_op == SPAG_OP_PUSH && i_stk_src != SPAG_SRC_DATA)
                    next_state = SPAG_ST_HIGH;
            SPAG_ST_HIGH:
                next_state = SPAG_ST_DONE;
            SPAG_ST_DONE:
                next_state = SPAG_ST_IDLE;
            default:
                next_state = SPAG_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state <= SPAG_ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            save_src <= SPAG_SRC_DATA;
        else if (state == SPAG_ST_IDLE)
            save_src <= i_stk_src;
    end

    assign upper_half = (state == SPAG_ST_HIGH);

    spag_stack_word u_word
    (
        .i_pc(i_pc),
        .i_status_low(i_status_low),
        .i_src(upper_half ? save_src : i_stk_src),
        .i_upper(upper_half),
        .i_data(i_stk_data),
        .o_word(push_word)
    );

    // Stack pointer next value; pipeline ops win over a software write.
    always_comb
    begin
        next_sp = stack_pointer_reg;
        if (upper_half)
            next_sp = sp_step(stack_pointer_reg, 1'b1); // [RL5] [RL6]
        else if (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_PUSH)
            next_sp = sp_step(stack_pointer_reg, 1'b1); // [RL4] [RL5]
        else if (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_POP)
            next_sp = sp_step(stack_pointer_reg, 1'b0); // [RL5]
        else if (i_reg.wr && i_reg.addr == REG_STACK_PTR)
            next_sp = sp_align(i_reg.wdata); // [RL1] [RL2]
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            stack_pointer_reg <= SP_RESET; // [RL3]
        else
            stack_pointer_reg <= next_sp; // [RL1]
    end

    // Stack memory request; pop address is the decremented pointer.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_stk_valid <= 1'b0;
            o_stk_write <= 1'b0;
            o_stk_addr <= 16'h0000;
            o_stk_wdata <= 16'h0000;
        end
        else
        begin
            o_stk_valid <= upper_half ||
                (state == SPAG_ST_IDLE && i_stk_op != SPAG_OP_NONE);
            o_stk_write <= upper_half || i_stk_op == SPAG_OP_PUSH;
            o_stk_wdata <= push_word; // [RL6] [RL7] [RL8]
            if (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_POP)
                o_stk_addr <= sp_step(stack_pointer_reg, 1'b0); // [RL5]
            else
                o_stk_addr <= stack_pointer_reg; // [RL4] [RL9]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_stk_busy <= 1'b0;
        else
            o_stk_busy <= (next_state == SPAG_ST_HIGH);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            frame_pointer_reg <= 16'h0000;
        else if (i_reg.wr && i_reg.addr == REG_FRAME_PTR)
            frame_pointer_reg <= i_reg.wdata;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            core_control <= CORE_CTRL_RESET;
        else if (i_reg.wr && i_reg.addr == REG_CORE_CTRL)
            core_control <= i_reg.wdata & CORE_CTRL_WMASK; // [RL10]
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            read_page_reg <= RD_PAGE_RESET;
            write_page_reg <= WR_PAGE_RESET;
        end
        else
        begin
            if (i_reg.wr && i_reg.addr == REG_RD_PAGE)
                read_page_reg <= i_reg.wdata[9:0]; // [RL14]
            if (i_reg.wr && i_reg.addr == REG_WR_PAGE)
                write_page_reg <= i_reg.wdata[8:0]; // [RL14]
        end
    end

    // Stack pointer refs are never paged; frame ones only when active.
    assign stack_ref = i_acc_stack ||
        (i_acc_frame && core_control[SFA_BIT]); // [RL9] [RL10]

    spag_pager u_pager
    (
        .i_ea(i_acc_ea),
        .i_write(i_acc_write),
        .i_stack_ref(stack_ref),
        .i_rd_page(read_page_reg),
        .i_wr_page(write_page_reg),
        .o_xlat(xlat)
    );

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_acc_valid <= 1'b0;
            o_acc_xlat <= '0;
        end
        else
        begin
            o_acc_valid <= i_acc_valid;
            o_acc_xlat <= xlat; // [RL11] [RL12] [RL13]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_stack_ptr <= SP_RESET;
        else
            o_stack_ptr <= next_sp;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 16'h0000;
        else if (i_reg.rd)
        begin
            case (i_reg.addr)
                REG_CORE_CTRL: o_rdata <= core_control;
                REG_STACK_PTR: o_rdata <= stack_pointer_reg;
                REG_FRAME_PTR: o_rdata <= frame_pointer_reg;
                REG_RD_PAGE: o_rdata <= {6'h00, read_page_reg};
                REG_WR_PAGE: o_rdata <= {7'h00, write_page_reg};
                default: o_rdata <= 16'h0000;
            endcase
        end
        else
            o_rdata <= 16'h0000;
    end

    a_sp_lsb_zero: assert property (stack_pointer_reg[0] == 1'b0) // [RL2]
        else $error("stack pointer bit zero set");

    a_push_step_two: assert property ( // [RL15]
        (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_PUSH)
        |=> stack_pointer_reg == $past(stack_pointer_reg) + SP_STEP)
        else $error("push did not add two");

    a_pop_step_two: assert property ( // [RL15]
        (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_POP)
        |=> stack_pointer_reg == $past(stack_pointer_reg) - SP_STEP)
        else $error("pop did not subtract two");

    a_pop_pre_dec: assert property ( // [RL5]
        (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_POP)
        |=> o_stk_addr == $past(stack_pointer_reg) - SP_STEP &&
            o_stk_valid && !o_stk_write)
        else $error("pop read wrong address");

    a_push_post_inc: assert property ( // [RL5]
        (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_PUSH)
        |=> o_stk_addr == $past(stack_pointer_reg) &&
            o_stk_valid && o_stk_write)
        else $error("push wrote wrong address");

    a_call_zero_fill: assert property ( // [RL7]
        (upper_half && save_src == SPAG_SRC_CALL)
        |=> o_stk_wdata[15:7] == 9'h000 &&
            o_stk_wdata[6:0] == $past(i_pc[22:16]))
        else $error("call upper word not zero filled");

    a_exc_status: assert property ( // [RL8]
        (upper_half && save_src == SPAG_SRC_EXC)
        |=> o_stk_wdata[15:8] == $past(i_status_low) &&
            o_stk_wdata[6:0] == $past(i_pc[22:16]))
        else $error("status low byte not stacked");

    a_pc_low_first: assert property ( // [RL6]
        (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_PUSH &&
         i_stk_src != SPAG_SRC_DATA)
        |=> o_stk_wdata == $past(i_pc[15:0]) ##1
            o_stk_addr == $past(o_stk_addr) + SP_STEP)
        else $error("pc halves out of order");

    a_save_busy_once: assert property ( // [RL6]
        (state == SPAG_ST_IDLE && i_stk_op == SPAG_OP_PUSH &&
         i_stk_src != SPAG_SRC_DATA)
        |=> o_stk_busy ##1 (!o_stk_busy && o_stk_valid && o_stk_write))
        else $error("second pc word not stored once");

    a_stack_unpaged: assert property ( // [RL9]
        (i_acc_valid && stack_ref)
        |=> !o_acc_xlat.paged && o_acc_xlat.addr[23:16] == 8'h00)
        else $error("stack access was paged");

    a_unpaged_direct: assert property ( // [RL9]
        (o_acc_valid && !o_acc_xlat.paged)
        |-> o_acc_xlat.addr == {8'h00, $past(i_acc_ea)})
        else $error("unpaged access address altered");

    a_window_offset: assert property ( // [RL11]
        (o_acc_valid && o_acc_xlat.paged)
        |-> o_acc_xlat.addr[14:0] == $past(i_acc_ea[14:0]))
        else $error("window offset lost");

    a_psv_by_page: assert property ( // [RL12]
        (o_acc_valid && o_acc_xlat.paged && !$past(i_acc_write))
        |-> o_acc_xlat.to_program == ($past(read_page_reg) >= PSV_THRESHOLD))
        else $error("program space select wrong");

    a_write_no_prog: assert property ( // [RL13]
        (o_acc_valid && o_acc_xlat.paged && $past(i_acc_write))
        |-> !o_acc_xlat.to_program)
        else $error("paged write reached program space");

    c_call_push: cover property (upper_half && save_src == SPAG_SRC_CALL);
    c_exc_push: cover property (upper_half && save_src == SPAG_SRC_EXC);
    c_psv_read: cover property (o_acc_valid && o_acc_xlat.to_program);
    c_data_pop: cover property (o_stk_valid && !o_stk_write);
endmodule : spag_core
`default_nettype wire

//--- hw/spag_pager.sv
// Page translation of one data-space effective address.
`timescale 1ns/1ns
`default_nettype none
module spag_pager
(
    // Access
    input wire logic [15:0] i_ea,
    input wire logic i_write,
    input wire logic i_stack_ref,
    // Pages
    input wire logic [9:0] i_rd_page,
    input wire logic [8:0] i_wr_page,
    // Result
    output spag_pkg::spag_xlat_s o_xlat
);
    import spag_pkg::*;

    always_comb
    begin
        o_xlat = '0;
        o_xlat.addr = {8'h00, i_ea};
        if (i_ea[PAGE_SEL_BIT] && !i_stack_ref) // [RL9] [RL10] [RL11]
        begin
            o_xlat.paged = 1'b1;
            if (i_write)
            begin
                // [RL13] [RL14]
                o_xlat.addr = {i_wr_page[7:0], 1'b0, i_ea[14:0]};
                o_xlat.refused = i_wr_page[8];
            end
            else
            begin
                // [RL12] [RL14]
                o_xlat.addr = {i_rd_page[8:0], i_ea[14:0]};
                o_xlat.to_program = (i_rd_page >= PSV_THRESHOLD);
            end
        end
    end
endmodule : spag_pager
`default_nettype wire

//--- hw/spag_pkg.sv
// Package of constants and carriers for the stack and paging block.
package spag_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 24;
    localparam logic [15:0] SP_RESET = 16'h1000;
    localparam logic [15:0] SP_STEP = 16'h0002;
    localparam logic [15:0] CORE_CTRL_RESET = 16'h0020;
    localparam logic [15:0] CORE_CTRL_WMASK = 16'hb0f7;
    localparam int SFA_BIT = 2;
    localparam logic [9:0] PSV_THRESHOLD = 10'h200;
    localparam logic [9:0] RD_PAGE_RESET = 10'h001;
    localparam logic [8:0] WR_PAGE_RESET = 9'h001;
    localparam int PAGE_SEL_BIT = 15;
    localparam logic [15:0] WIN_OFS_MASK = 16'h7fff;
    // Register port addresses.
    localparam logic [3:0] REG_CORE_CTRL = 4'h0;
    localparam logic [3:0] REG_STACK_PTR = 4'h1;
    localparam logic [3:0] REG_FRAME_PTR = 4'h2;
    localparam logic [3:0] REG_RD_PAGE = 4'h3;
    localparam logic [3:0] REG_WR_PAGE = 4'h4;

    typedef enum logic [1:0]
    {
        SPAG_OP_NONE = 2'h0,
        SPAG_OP_PUSH = 2'h1,
        SPAG_OP_POP = 2'h2
    } spag_op_e;

    typedef enum logic [1:0]
    {
        SPAG_SRC_DATA = 2'h0,
        SPAG_SRC_CALL = 2'h1,
        SPAG_SRC_EXC = 2'h2
    } spag_src_e;

    // Translated address with the space it lands in.
    typedef struct packed
    {
        logic [23:0] addr;
        logic to_program;
        logic paged;
        logic refused;
    } spag_xlat_s;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } spag_reg_req_s;
endpackage : spag_pkg

//--- hw/spag_stack_word.sv
// Forms the word pushed for each half of a saved program counter.
`timescale 1ns/1ns
`default_nettype none
module spag_stack_word
(
    // Source
    input wire logic [22:0] i_pc,
    input wire logic [7:0] i_status_low,
    input wire spag_pkg::spag_src_e i_src,
    input wire logic i_upper,
    input wire logic [15:0] i_data,
    // Word
    output logic [15:0] o_word
);
    import spag_pkg::*;

    always_comb
    begin
        o_word = i_data;
        if (i_src != SPAG_SRC_DATA)
        begin
            if (!i_upper)
                o_word = i_pc[15:0]; // [RL6]
            else if (i_src == SPAG_SRC_EXC)
                o_word = {i_status_low, 1'b0, i_pc[22:16]}; // [RL8]
            else
                o_word = {9'h000, i_pc[22:16]}; // [RL7]
        end
    end
endmodule : spag_stack_word
`default_nettype wire

//--- testbench/spag_stack_ram.sv
// Stack memory on the core's memory side, fed by the core's stack requests.
`timescale 1ns/1ns
`default_nettype none
module spag_stack_ram
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Request from the core
    input wire logic i_valid,
    input wire logic i_write,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    // Last request seen
    output logic [15:0] o_last_addr,
    output logic o_last_write
);
    logic [15:0] mem [0:32767];

    // Words only: bit zero of the address is dropped, so a misaligned
    // request from the core would land on the aligned word and go unnoticed.
    always_ff @(posedge i_clk)
    begin
        if (i_valid && i_write)
            mem[i_addr[15:1]] <= i_wdata;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_last_addr <= 16'h0000;
            o_last_write <= 1'b0;
        end
        else if (i_valid)
        begin
            o_last_addr <= i_addr;
            o_last_write <= i_write;
        end
    end

    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem[a[15:1]];
    endfunction : peek
endmodule : spag_stack_ram
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the stack pointer and paging core.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import spag_pkg::*;
    logic i_clk, i_rst_n, i_acc_valid, i_acc_write, i_acc_frame, i_acc_stack;
    spag_reg_req_s i_reg;
    spag_op_e i_stk_op;
    spag_src_e i_stk_src;
    logic [15:0] i_stk_data, i_acc_ea, o_rdata, o_stk_addr, o_stk_wdata;
    logic [15:0] o_stack_ptr, last_addr, sp_exp, rd, d;
    logic [22:0] i_pc;
    logic [7:0] i_status_low;
    logic o_stk_valid, o_stk_write, o_stk_busy, o_acc_valid, o_sfa, last_wr;
    spag_xlat_s o_acc_xlat;
    logic [9:0] rp;
    logic [8:0] wp;
    int error_cnt, n_checks, seed, i;

    spag_core u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg(i_reg),
        .o_rdata(o_rdata), .i_stk_op(i_stk_op), .i_stk_src(i_stk_src),
        .i_stk_data(i_stk_data), .i_pc(i_pc), .i_status_low(i_status_low),
        .i_acc_valid(i_acc_valid), .i_acc_write(i_acc_write),
        .i_acc_frame(i_acc_frame), .i_acc_stack(i_acc_stack),
        .i_acc_ea(i_acc_ea), .o_stk_valid(o_stk_valid),
        .o_stk_write(o_stk_write), .o_stk_addr(o_stk_addr),
        .o_stk_wdata(o_stk_wdata), .o_stk_busy(o_stk_busy),
        .o_acc_valid(o_acc_valid), .o_acc_xlat(o_acc_xlat),
        .o_stack_ptr(o_stack_ptr), .o_stack_frame_active(o_sfa));

    spag_stack_ram u_ram (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_valid(o_stk_valid), .i_write(o_stk_write), .i_addr(o_stk_addr),
        .i_wdata(o_stk_wdata), .o_last_addr(last_addr),
        .o_last_write(last_wr));

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk16(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    task automatic chkx(input spag_xlat_s e, input spag_xlat_s g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] xlat expected %h seen %h", e, g);
        end
    endtask : chkx

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_reg <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_reg.wr <= 1'b0;
        #1;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_clk);
        i_reg <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_reg.rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask : reg_rd

    // The pipeline may not issue while busy, so wait it out, bounded.
    task automatic stk(input spag_op_e op, input spag_src_e src);
        int n;
        logic two;
        two = (op == SPAG_OP_PUSH && src != SPAG_SRC_DATA);
        @(posedge i_clk);
        i_stk_op <= op;
        i_stk_src <= src;
        @(posedge i_clk);
        i_stk_op <= SPAG_OP_NONE;
        #1;
        chk16("stk_busy", {15'h0000, two}, {15'h0000, o_stk_busy});
        repeat (3) @(posedge i_clk);
        for (n = 0; n < 8 && o_stk_busy !== 1'b0; n++)
            @(posedge i_clk);
        #1;
    endtask : stk

    function automatic spag_xlat_s xl(input logic w, st, fr, stack_frame_active,
                                      input logic [15:0] ea);
        spag_xlat_s x;
        x = '0;
        if (!ea[15] || st || (fr && stack_frame_active))
            x.addr = {8'h00, ea};
        else if (w)
        begin
            x.addr = {wp[7:0], 1'b0, ea[14:0]};
            x.paged = 1'b1;
            x.refused = wp[8];
        end
        else
        begin
            x.addr = {rp[8:0], ea[14:0]};
            x.paged = 1'b1;
            x.to_program = (rp >= PSV_THRESHOLD);
        end
        return x;
    endfunction : xl

    task automatic acc(input logic w, st, fr, stack_frame_active, input logic [15:0] ea);
        @(posedge i_clk);
        i_acc_valid <= 1'b1;
        i_acc_write <= w;
        i_acc_stack <= st;
        i_acc_frame <= fr;
        i_acc_ea <= ea;
        @(posedge i_clk);
        i_acc_valid <= 1'b0;
        #1;
        chk16("acc_valid", 16'h0001, {15'h0000, o_acc_valid});
        chkx(xl(w, st, fr, stack_frame_active, ea), o_acc_xlat);
    endtask : acc

    initial
    begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        test_done();
    end

    initial
    begin
        seed = 32'he4e275d1;
        i_rst_n = 1'b0;
        i_reg = '0;
        i_stk_op = SPAG_OP_NONE;
        i_stk_src = SPAG_SRC_DATA;
        i_stk_data = 16'h0000;
        i_pc = 23'h000000;
        i_status_low = 8'h00;
        {i_acc_valid, i_acc_write, i_acc_frame, i_acc_stack} = 4'h0;
        i_acc_ea = 16'h0000;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        reg_rd(REG_STACK_PTR, rd);
        chk16("sp_reset", SP_RESET, rd);
        reg_rd(REG_CORE_CTRL, rd);
        chk16("ctrl_reset", CORE_CTRL_RESET, rd);
        reg_rd(REG_RD_PAGE, rd);
        chk16("rpage_reset", {6'h00, RD_PAGE_RESET}, rd);
        reg_rd(REG_WR_PAGE, rd);
        chk16("wpage_reset", {7'h00, WR_PAGE_RESET}, rd);
        reg_rd(4'h7, rd);
        chk16("unmapped", 16'h0000, rd);
        reg_rd(REG_FRAME_PTR, rd);
        chk16("fp_reset", 16'h0000, rd);
        $display("test reset_values done");
        reg_wr(REG_STACK_PTR, 16'h2345);
        reg_rd(REG_STACK_PTR, rd);
        chk16("sp_write", 16'h2344, rd);
        reg_wr(REG_FRAME_PTR, 16'h2345);
        reg_rd(REG_FRAME_PTR, rd);
        chk16("fp_write", 16'h2345, rd);
        sp_exp = 16'h2344;
        for (i = 0; i < 6; i++)
        begin
            d = $random(seed);
            i_stk_data <= d;
            stk(SPAG_OP_PUSH, SPAG_SRC_DATA);
            chk16("push_word", d, u_ram.peek(sp_exp));
            sp_exp = sp_exp + SP_STEP;
            chk16("sp_push", sp_exp, o_stack_ptr);
        end
        for (i = 0; i < 6; i++)
        begin
            stk(SPAG_OP_POP, SPAG_SRC_DATA);
            sp_exp = sp_exp - SP_STEP;
            chk16("pop_addr", sp_exp, last_addr);
            chk16("pop_kind", 16'h0000, {15'h0000, last_wr});
            chk16("sp_pop", sp_exp, o_stack_ptr);
        end
        $display("test data_stack done");
        for (i = 0; i < 4; i++)
        begin
            i_pc <= 23'($random(seed));
            i_status_low <= 8'($random(seed));
            stk(SPAG_OP_PUSH, i[0] ? SPAG_SRC_EXC : SPAG_SRC_CALL);
            chk16("pc_low", i_pc[15:0], u_ram.peek(sp_exp));
            d = i[0] ? {i_status_low, 1'b0, i_pc[22:16]}
                     : {9'h000, i_pc[22:16]};
            chk16("pc_high", d, u_ram.peek(sp_exp + 16'h0002));
            sp_exp = sp_exp + 16'h0004;
            chk16("sp_pc", sp_exp, o_stack_ptr);
        end
        $display("test pc_save done");
        for (i = 0; i < 12; i++)
        begin
            rp = {i[0], 9'($random(seed))};
            wp = 9'($random(seed));
            reg_wr(REG_RD_PAGE, {6'h00, rp});
            reg_wr(REG_WR_PAGE, {7'h00, wp});
            reg_wr(REG_CORE_CTRL, i[1] ? 16'h0024 : 16'h0020);
            chk16("sfa", {15'h0000, i[1]}, {15'h0000, o_sfa});
            d = $random(seed);
            acc(1'b0, 1'b0, 1'b0, i[1], d | 16'h8000);
            acc(1'b1, 1'b0, 1'b0, i[1], d | 16'h8000);
            acc(1'b0, 1'b0, 1'b0, i[1], d & 16'h7fff);
            acc(i[2], 1'b1, 1'b0, i[1], d | 16'h8000);
            acc(i[2], 1'b0, 1'b1, i[1], d | 16'h8000);
        end
        $display("test paging done");
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        chk16("sp_rereset", SP_RESET, o_stack_ptr);
        chk16("sfa_rereset", 16'h0000, {15'h0000, o_sfa});
        reg_rd(REG_STACK_PTR, rd);
        chk16("sp_rereset_rd", SP_RESET, rd);
        $display("test second_reset done");
        test_done();
    end
endmodule : tb
`default_nettype wire
